// File: core/gpd_pkg.sv
// Package holding register map, field layout and reset values of the port block.
`default_nettype none
package gpd_pkg;
    localparam logic [15:0] GPD_ADDR_DIR0    = 16'hFF20;
    localparam logic [15:0] GPD_ADDR_DIR1    = 16'hFF21;
    localparam logic [15:0] GPD_ADDR_DIR2    = 16'hFF22;
    localparam logic [15:0] GPD_ADDR_DIR3    = 16'hFF23;
    localparam logic [15:0] GPD_ADDR_DIR5    = 16'hFF25;
    localparam logic [15:0] GPD_ADDR_PU2     = 16'hFF32;
    localparam logic [15:0] GPD_ADDR_PU3     = 16'hFF33;
    localparam logic [15:0] GPD_ADDR_PU01    = 16'hFFF7;
    localparam logic [15:0] GPD_ADDR_PORT0   = 16'hFF00;
    localparam logic [15:0] GPD_ADDR_PORT1   = 16'hFF01;
    localparam logic [15:0] GPD_ADDR_PORT2   = 16'hFF02;
    localparam logic [15:0] GPD_ADDR_PORT3   = 16'hFF03;
    localparam logic [15:0] GPD_ADDR_PORT5   = 16'hFF05;
    localparam logic [7:0]  GPD_DIR_RST      = 8'hFF;
    localparam logic [7:0]  GPD_PU_RST       = 8'h00;
    localparam logic [7:0]  GPD_LATCH_RST    = 8'h00;
    localparam logic [7:0]  GPD_FIX4_MASK    = 8'hF0;
    localparam logic [7:0]  GPD_FIX7_MASK    = 8'h80;
    localparam logic [7:0]  GPD_PU01_MASK    = 8'h03;
    localparam logic [7:0]  GPD_PU2_MASK     = 8'h7F;
    localparam logic [7:0]  GPD_PU3_MASK     = 8'h0F;
    localparam int          GPD_PU01_P0_BIT  = 0;
    localparam int          GPD_PU01_P1_BIT  = 1;
    localparam int          GPD_NPORT        = 5;
endpackage
`default_nettype wire

// File: core/gpd_reg8.sv
// Byte-wide register with bit or byte write and forced-one or forced-zero bits.
`default_nettype none
module gpd_reg8 #(
    parameter logic [7:0] RST   = 8'h00,
    parameter logic [7:0] ONES  = 8'h00,
    parameter logic [7:0] ZEROS = 8'h00
) (
    // Clock and reset
    input  wire logic       mclk_i,
    input  wire logic       rst_b_i,
    // Write side
    input  wire logic       wr_i,
    input  wire logic       bit_i,
    input  wire logic [2:0] sel_i,
    input  wire logic [7:0] wdata_i,
    // Contents
    output var  logic [7:0] q_o
);
    logic [7:0] d;

    always_comb begin
        d = q_o;
        if (wr_i) begin
            if (bit_i) begin
                d[sel_i] = wdata_i[0];
            end else begin
                d = wdata_i;
            end
        end
        d = (d | ONES) & ~ZEROS;
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q_o <= RST;
        end else begin
            q_o <= d;
        end
    end
endmodule
`default_nettype wire

// File: core/gpd_port.sv
// Port control top: direction, pull-up, output latches and pin read paths.
`default_nettype none
// Function
// RULE1: Per-pin direction bit, zero output, one input.
// RULE2: Reset loads every direction register with ones.
// RULE3: Direction and pull-up take bit or byte writes.
// RULE4: Software sets direction for alternate functions.
// RULE5: Port-3 output level change sets interrupt flag.
// RULE6: Software masks interrupt before port-3 output use.
// RULE7: Pull-up only applies while pin is input.
// RULE8: Group pull-up bits for ports 0, 1.
// RULE9: Port-2 pull-up bits per pin, reset clear.
// RULE10: Port-3 pull-up bits per pin, reset clear.
// RULE11: Software writes zero to unused pull-up bits.
// RULE12: Output-mode write loads latch, drives pins.
// RULE13: Input-mode write updates latch, pin unchanged.
// RULE14: Output-mode read returns latch, latch unchanged.
// RULE15: Input-mode read returns pin, latch unchanged.
// RULE16: Bit operation on port is byte read-modify-write.
// RULE17: Arithmetic result written back to latch, driven.
// RULE18: Port 5 open-drain, no software pull-up.
// RULE19: Ports 0, 1 pull-up act on whole port.
// RULE20: Unbacked direction bits fixed and read one.
// RULE21: Latches writable in input mode for preload.
module gpd_port
    import gpd_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk_i,
    input  wire logic       rst_b_i,
    // Processor memory access
    input  wire logic [15:0] addr_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire logic        bit_i,
    input  wire logic [2:0]  bit_sel_i,
    input  wire logic [7:0]  wdata_i,
    output var  logic [7:0]  rdata_o,
    output var  logic        rvalid_o,
    // Pin levels
    input  wire logic [3:0]  p0_pin_i,
    input  wire logic [3:0]  p1_pin_i,
    input  wire logic [6:0]  p2_pin_i,
    input  wire logic [3:0]  p3_pin_i,
    input  wire logic [3:0]  p5_pin_i,
    // Pin drive
    output var  logic [3:0]  p0_pin_o,
    output var  logic [3:0]  p0_pin_oe_o,
    output var  logic [3:0]  p0_pullup_o,
    output var  logic [3:0]  p1_pin_o,
    output var  logic [3:0]  p1_pin_oe_o,
    output var  logic [3:0]  p1_pullup_o,
    output var  logic [6:0]  p2_pin_o,
    output var  logic [6:0]  p2_pin_oe_o,
    output var  logic [6:0]  p2_pullup_o,
    output var  logic [3:0]  p3_pin_o,
    output var  logic [3:0]  p3_pin_oe_o,
    output var  logic [3:0]  p3_pullup_o,
    output var  logic [3:0]  p5_pin_o,
    output var  logic [3:0]  p5_pin_oe_o,
    // Interrupt request set pulses toward the interrupt flags
    output var  logic [3:0]  ext_irq_set_o
);
    logic [7:0] dir0, dir1, dir2, dir3, dir5;
    logic [7:0] pu01, pu2, pu3;
    logic [7:0] lat0_q, lat1_q, lat2_q, lat3_q, lat5_q;
    logic [7:0] lat0_d, lat1_d, lat2_d, lat3_d, lat5_d;
    logic [7:0] rdata_d;
    logic       rvalid_d;
    logic [3:0] p0_oe_d, p1_oe_d, p3_oe_d, p5_oe_d;
    logic [6:0] p2_oe_d;
    logic [3:0] p0_pu_d, p1_pu_d, p3_pu_d;
    logic [6:0] p2_pu_d;
    logic [3:0] p5_o_d;
    logic [3:0] irq_d;
    logic [3:0] p3_drv_now;
    logic [7:0] pin0, pin1, pin2, pin3, pin5;
    logic [7:0] rd0, rd1, rd2, rd3, rd5;
    logic       w_d0, w_d1, w_d2, w_d3, w_d5, w_pu01, w_pu2, w_pu3;

    // Register write strobes.
    assign w_d0   = wr_i && addr_i == GPD_ADDR_DIR0;
    assign w_d1   = wr_i && addr_i == GPD_ADDR_DIR1;
    assign w_d2   = wr_i && addr_i == GPD_ADDR_DIR2;
    assign w_d3   = wr_i && addr_i == GPD_ADDR_DIR3;
    assign w_d5   = wr_i && addr_i == GPD_ADDR_DIR5;
    assign w_pu01 = wr_i && addr_i == GPD_ADDR_PU01;
    assign w_pu2  = wr_i && addr_i == GPD_ADDR_PU2;
    assign w_pu3  = wr_i && addr_i == GPD_ADDR_PU3;

    // Direction registers reset to input; unbacked bits stay one. [RULE1] [RULE2] [RULE3] [RULE20]
    gpd_reg8 #(.RST(GPD_DIR_RST), .ONES(GPD_FIX4_MASK), .ZEROS(8'h00)) u_dir0 (
        .mclk_i (mclk_i),
        .rst_b_i(rst_b_i),
        .wr_i   (w_d0),
        .bit_i  (bit_i),
        .sel_i  (bit_sel_i),
        .wdata_i(wdata_i),
        .q_o    (dir0)
    );
    gpd_reg8 #(.RST(GPD_DIR_RST), .ONES(GPD_FIX4_MASK), .ZEROS(8'h00)) u_dir1 (
        .mclk_i (mclk_i),
        .rst_b_i(rst_b_i),
        .wr_i   (w_d1),
        .bit_i  (bit_i),
        .sel_i  (bit_sel_i),
        .wdata_i(wdata_i),
        .q_o    (dir1)
    );
    gpd_reg8 #(.RST(GPD_DIR_RST), .ONES(GPD_FIX7_MASK), .ZEROS(8'h00)) u_dir2 (
        .mclk_i (mclk_i),
        .rst_b_i(rst_b_i),
        .wr_i   (w_d2),
        .bit_i  (bit_i),
        .sel_i  (bit_sel_i),
        .wdata_i(wdata_i),
        .q_o    (dir2)
    );
    gpd_reg8 #(.RST(GPD_DIR_RST), .ONES(GPD_FIX4_MASK), .ZEROS(8'h00)) u_dir3 (
        .mclk_i (mclk_i),
        .rst_b_i(rst_b_i),
        .wr_i   (w_d3),
        .bit_i  (bit_i),
        .sel_i  (bit_sel_i),
        .wdata_i(wdata_i),
        .q_o    (dir3)
    );
    gpd_reg8 #(.RST(GPD_DIR_RST), .ONES(GPD_FIX4_MASK), .ZEROS(8'h00)) u_dir5 (
        .mclk_i (mclk_i),
        .rst_b_i(rst_b_i),
        .wr_i   (w_d5),
        .bit_i  (bit_i),
        .sel_i  (bit_sel_i),
        .wdata_i(wdata_i),
        .q_o    (dir5)
    );

    // Pull-up enables; unused bits are held at zero so a careless write does no harm. [RULE3] [RULE8] [RULE9] [RULE10]
    gpd_reg8 #(.RST(GPD_PU_RST), .ONES(8'h00), .ZEROS(~GPD_PU01_MASK)) u_pu01 (
        .mclk_i (mclk_i),
        .rst_b_i(rst_b_i),
        .wr_i   (w_pu01),
        .bit_i  (bit_i),
        .sel_i  (bit_sel_i),
        .wdata_i(wdata_i),
        .q_o    (pu01)
    );
    gpd_reg8 #(.RST(GPD_PU_RST), .ONES(8'h00), .ZEROS(~GPD_PU2_MASK)) u_pu2 (
        .mclk_i (mclk_i),
        .rst_b_i(rst_b_i),
        .wr_i   (w_pu2),
        .bit_i  (bit_i),
        .sel_i  (bit_sel_i),
        .wdata_i(wdata_i),
        .q_o    (pu2)
    );
    gpd_reg8 #(.RST(GPD_PU_RST), .ONES(8'h00), .ZEROS(~GPD_PU3_MASK)) u_pu3 (
        .mclk_i (mclk_i),
        .rst_b_i(rst_b_i),
        .wr_i   (w_pu3),
        .bit_i  (bit_i),
        .sel_i  (bit_sel_i),
        .wdata_i(wdata_i),
        .q_o    (pu3)
    );

    assign pin0 = {4'h0, p0_pin_i};
    assign pin1 = {4'h0, p1_pin_i};
    assign pin2 = {1'b0, p2_pin_i};
    assign pin3 = {4'h0, p3_pin_i};
    assign pin5 = {4'h0, p5_pin_i};

    // Port read mixes latch for outputs and pin for inputs. [RULE14] [RULE15]
    assign rd0 = (lat0_q & ~dir0) | (pin0 & dir0);
    assign rd1 = (lat1_q & ~dir1) | (pin1 & dir1);
    assign rd2 = (lat2_q & ~dir2) | (pin2 & dir2);
    assign rd3 = (lat3_q & ~dir3) | (pin3 & dir3);
    assign rd5 = (lat5_q & ~dir5) | (pin5 & dir5);

    // Latch update. A bit write is a byte read-modify-write, so untargeted input pins
    // take their pin level into the latch; that is the undefined content software sees.
    function automatic logic [7:0] latch_next(input logic [7:0] q, input logic [7:0] rd,
                                              input logic hit);
        logic [7:0] v;
        v = q;
        if (hit) begin
            if (bit_i) begin
                v = rd; // [RULE16]
                v[bit_sel_i] = wdata_i[0];
            end else begin
                v = wdata_i; // [RULE12] [RULE13] [RULE17] [RULE21]
            end
        end
        return v;
    endfunction

    always_comb begin
        lat0_d = latch_next(lat0_q, rd0, wr_i && addr_i == GPD_ADDR_PORT0);
        lat1_d = latch_next(lat1_q, rd1, wr_i && addr_i == GPD_ADDR_PORT1);
        lat2_d = latch_next(lat2_q, rd2, wr_i && addr_i == GPD_ADDR_PORT2);
        lat3_d = latch_next(lat3_q, rd3, wr_i && addr_i == GPD_ADDR_PORT3);
        lat5_d = latch_next(lat5_q, rd5, wr_i && addr_i == GPD_ADDR_PORT5);
    end

    // Read mux; unmapped addresses return zero.
    always_comb begin
        rvalid_d = rd_i;
        case (addr_i)
            GPD_ADDR_DIR0:  rdata_d = dir0; // [RULE20]
            GPD_ADDR_DIR1:  rdata_d = dir1;
            GPD_ADDR_DIR2:  rdata_d = dir2;
            GPD_ADDR_DIR3:  rdata_d = dir3;
            GPD_ADDR_DIR5:  rdata_d = dir5;
            GPD_ADDR_PU01:  rdata_d = pu01;
            GPD_ADDR_PU2:   rdata_d = pu2;
            GPD_ADDR_PU3:   rdata_d = pu3;
            GPD_ADDR_PORT0: rdata_d = rd0;
            GPD_ADDR_PORT1: rdata_d = rd1;
            GPD_ADDR_PORT2: rdata_d = rd2;
            GPD_ADDR_PORT3: rdata_d = rd3;
            GPD_ADDR_PORT5: rdata_d = rd5;
            default:        rdata_d = 8'h00;
        endcase
        if (!rd_i) begin
            rdata_d = rdata_o;
        end
    end

    // Pin drive: buffer on when direction bit is zero, on port 5 only while the latch bit is also zero; pull-up only in input mode.
    always_comb begin
        p0_oe_d = ~dir0[3:0]; // [RULE1]
        p1_oe_d = ~dir1[3:0];
        p2_oe_d = ~dir2[6:0];
        p3_oe_d = ~dir3[3:0];
        p0_pu_d = {4{pu01[GPD_PU01_P0_BIT]}} & dir0[3:0]; // [RULE7] [RULE19]
        p1_pu_d = {4{pu01[GPD_PU01_P1_BIT]}} & dir1[3:0]; // [RULE7] [RULE19]
        p2_pu_d = pu2[6:0] & dir2[6:0]; // [RULE7]
        p3_pu_d = pu3[3:0] & dir3[3:0]; // [RULE7]
        p5_oe_d = ~dir5[3:0] & ~lat5_d[3:0]; // [RULE18]
        p5_o_d  = 4'h0; // [RULE18]
        p3_drv_now = lat3_d[3:0];
        // A driven output level change looks like an edge to the interrupt logic.
        irq_d = ~dir3[3:0] & (p3_drv_now ^ lat3_q[3:0]); // [RULE5]
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lat0_q        <= GPD_LATCH_RST;
            lat1_q        <= GPD_LATCH_RST;
            lat2_q        <= GPD_LATCH_RST;
            lat3_q        <= GPD_LATCH_RST;
            lat5_q        <= GPD_LATCH_RST;
            rdata_o       <= 8'h00;
            rvalid_o      <= 1'b0;
            p0_pin_o      <= 4'h0;
            p1_pin_o      <= 4'h0;
            p2_pin_o      <= 7'h00;
            p3_pin_o      <= 4'h0;
            p5_pin_o      <= 4'h0;
            p0_pin_oe_o   <= 4'h0;
            p1_pin_oe_o   <= 4'h0;
            p2_pin_oe_o   <= 7'h00;
            p3_pin_oe_o   <= 4'h0;
            p5_pin_oe_o   <= 4'h0;
            p0_pullup_o   <= 4'h0;
            p1_pullup_o   <= 4'h0;
            p2_pullup_o   <= 7'h00;
            p3_pullup_o   <= 4'h0;
            ext_irq_set_o <= 4'h0;
        end else begin
            lat0_q        <= lat0_d;
            lat1_q        <= lat1_d;
            lat2_q        <= lat2_d;
            lat3_q        <= lat3_d;
            lat5_q        <= lat5_d;
            rdata_o       <= rdata_d;
            rvalid_o      <= rvalid_d;
            p0_pin_o      <= lat0_d[3:0];
            p1_pin_o      <= lat1_d[3:0];
            p2_pin_o      <= lat2_d[6:0];
            p3_pin_o      <= lat3_d[3:0];
            p5_pin_o      <= p5_o_d;
            p0_pin_oe_o   <= p0_oe_d;
            p1_pin_oe_o   <= p1_oe_d;
            p2_pin_oe_o   <= p2_oe_d;
            p3_pin_oe_o   <= p3_oe_d;
            p5_pin_oe_o   <= p5_oe_d;
            p0_pullup_o   <= p0_pu_d;
            p1_pullup_o   <= p1_pu_d;
            p2_pullup_o   <= p2_pu_d;
            p3_pullup_o   <= p3_pu_d;
            ext_irq_set_o <= irq_d;
        end
    end

    // Drive levels follow the latch at the write edge; enables and pull-ups follow the
    // direction register one edge later, so a direction write reaches the pins a cycle late.

    a_dir_reset_in: assert property (@(posedge mclk_i) // [RULE2]
        $rose(rst_b_i) |-> dir0 == GPD_DIR_RST && dir5 == GPD_DIR_RST)
        else $error("direction not all ones after reset");
    a_dir_fixed_one: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RULE20]
        dir0[7:4] == 4'hF && dir2[7] && dir3[7:4] == 4'hF)
        else $error("unbacked direction bit not one");
    a_pu_in_only: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RULE7]
        ((p2_pullup_o & p2_pin_oe_o) == 7'h00) && ((p3_pullup_o & p3_pin_oe_o) == 4'h0))
        else $error("pull-up on output pin");
    a_group_pu: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RULE19]
        (pu01[GPD_PU01_P0_BIT] && dir0[3:0] == 4'hF) |=> p0_pullup_o == 4'hF)
        else $error("group pull-up missing");
    a_oe_follows_dir: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RULE1]
        w_d2 && !bit_i |-> ##2 p2_pin_oe_o == ~$past(wdata_i[6:0], 2))
        else $error("enable not tracking direction write");
    a_latch_byte_wr: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RULE13]
        wr_i && !bit_i && addr_i == GPD_ADDR_PORT1 |=> lat1_q == $past(wdata_i))
        else $error("latch write lost");
    a_read_out_latch: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RULE14]
        rd_i && addr_i == GPD_ADDR_PORT2 && dir2 == 8'h80 |=> rdata_o == $past(lat2_q) && rvalid_o)
        else $error("output-mode read not latch");
    a_read_in_pin: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RULE15]
        rd_i && addr_i == GPD_ADDR_PORT3 && dir3 == 8'hFF |=> rdata_o == {4'h0, $past(p3_pin_i)})
        else $error("input-mode read not pin");
    a_read_keeps: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RULE15]
        rd_i && !wr_i |=> $stable(lat0_q) && $stable(lat3_q))
        else $error("read disturbed latch");
    a_od_never_high: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RULE18]
        p5_pin_o == 4'h0 && (p5_pin_oe_o & ~$past(~dir5[3:0])) == 4'h0)
        else $error("open-drain pin driven high");
    a_irq_on_change: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RULE5]
        !dir3[0] && lat3_d[0] != lat3_q[0]
        |=> ext_irq_set_o[0] ##1 (!ext_irq_set_o[0] || $past(!dir3[0] && lat3_d[0] != lat3_q[0])))
        else $error("port-3 output change gave no interrupt");
    a_pu_masked: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RULE9]
        pu2[7] == 1'b0 && pu3[7:4] == 4'h0 && pu01[7:2] == 6'h00)
        else $error("unused pull-up bit set");
    a_irq_input_quiet: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RULE5]
        dir3[3:0] == 4'hF |=> ext_irq_set_o == 4'h0)
        else $error("port-3 input pin raised interrupt");
    a_rvalid_pulse: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RULE14]
        rvalid_o == $past(rd_i))
        else $error("read valid not one cycle after read");
    a_latch_holds: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RULE12]
        !wr_i |=> $stable(lat2_q) && $stable(lat5_q))
        else $error("latch changed without a write");
    a_bit_rmw: assert property (@(posedge mclk_i) disable iff (!rst_b_i) // [RULE16]
        wr_i && bit_i && addr_i == GPD_ADDR_PORT1 |=> lat1_q[$past(bit_sel_i)] == $past(wdata_i[0]))
        else $error("bit write missed its target");

    c_bit_rmw: cover property (@(posedge mclk_i) disable iff (!rst_b_i) wr_i && bit_i && addr_i == GPD_ADDR_PORT2);
    c_p3_irq: cover property (@(posedge mclk_i) disable iff (!rst_b_i) ext_irq_set_o != 4'h0);
    c_p5_low: cover property (@(posedge mclk_i) disable iff (!rst_b_i) p5_pin_oe_o != 4'h0);
    c_group_pu: cover property (@(posedge mclk_i) disable iff (!rst_b_i) p0_pullup_o == 4'hF);
    c_dir_bit: cover property (@(posedge mclk_i) disable iff (!rst_b_i) w_d2 && bit_i);
endmodule
`default_nettype wire

// File: bench/gpd_pin_model.sv
// Behavioural model of the pins and of whatever drives them from outside.
`default_nettype none
module gpd_pin_model #(
    parameter int W = 4
) (
    // Clock
    input  wire logic         mclk_i,
    // Block side
    input  wire logic [W-1:0] drv_i,
    input  wire logic [W-1:0] oe_i,
    input  wire logic [W-1:0] pu_i,
    // Outside drivers
    input  wire logic         ext_on_i,
    input  wire logic [W-1:0] ext_val_i,
    // Resolved pin level
    output var  logic [W-1:0] lvl_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [W-1:0] float_q = '0;
    // A floating pin toggles every cycle between all zeros and all ones, so a read of it gives whichever value its sampling cycle holds.
    always_ff @(posedge mclk_i) begin
        float_q <= ~float_q;
    end
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (oe_i[i]) begin
                lvl_o[i] = drv_i[i];
            end else if (ext_on_i) begin
                lvl_o[i] = ext_val_i[i];
            end else if (pu_i[i]) begin
                lvl_o[i] = 1'b1;
            end else begin
                lvl_o[i] = float_q[i];
            end
        end
    end
endmodule
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench for the port control block.
`default_nettype none
module testbench;
    import gpd_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic [15:0] addr_i = 16'h0000;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        bit_i = 1'b0;
    logic [2:0]  bit_sel_i = 3'h0;
    logic [7:0]  wdata_i = 8'h00;
    logic [7:0]  rdata_o;
    logic        rvalid_o;
    logic [3:0]  p0_i, p1_i, p3_i, p5_i, p0_o, p1_o, p3_o, p5_o, p0_oe, p1_oe, p3_oe, p5_oe;
    logic [3:0]  p0_pu, p1_pu, p3_pu, irq_set;
    logic [6:0]  p2_i, p2_o, p2_oe, p2_pu;
    logic        ext_on = 1'b1;
    logic [6:0]  x2 = 7'h2A;
    logic [3:0]  x0 = 4'h5;
    logic [3:0]  x1 = 4'h5;
    logic [3:0]  x3 = 4'h0;
    logic [3:0]  x5 = 4'hF;
    logic [15:0] dir_a [5] = '{GPD_ADDR_DIR0, GPD_ADDR_DIR1, GPD_ADDR_DIR2, GPD_ADDR_DIR3, GPD_ADDR_DIR5};
    int          err_total = 0;
    int          total_checks = 0;

    always #12.5 mclk_i = ~mclk_i;

    gpd_port gpd_port_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
        .bit_i(bit_i), .bit_sel_i(bit_sel_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
        .p0_pin_i(p0_i), .p1_pin_i(p1_i), .p2_pin_i(p2_i), .p3_pin_i(p3_i), .p5_pin_i(p5_i),
        .p0_pin_o(p0_o), .p0_pin_oe_o(p0_oe), .p0_pullup_o(p0_pu), .p1_pin_o(p1_o), .p1_pin_oe_o(p1_oe),
        .p1_pullup_o(p1_pu), .p2_pin_o(p2_o), .p2_pin_oe_o(p2_oe), .p2_pullup_o(p2_pu), .p3_pin_o(p3_o),
        .p3_pin_oe_o(p3_oe), .p3_pullup_o(p3_pu), .p5_pin_o(p5_o), .p5_pin_oe_o(p5_oe),
        .ext_irq_set_o(irq_set));
    gpd_pin_model #(.W(4)) m0_inst (.mclk_i(mclk_i), .drv_i(p0_o), .oe_i(p0_oe), .pu_i(p0_pu),
        .ext_on_i(ext_on), .ext_val_i(x0), .lvl_o(p0_i));
    gpd_pin_model #(.W(4)) m1_inst (.mclk_i(mclk_i), .drv_i(p1_o), .oe_i(p1_oe), .pu_i(p1_pu),
        .ext_on_i(ext_on), .ext_val_i(x1), .lvl_o(p1_i));
    gpd_pin_model #(.W(7)) m2_inst (.mclk_i(mclk_i), .drv_i(p2_o), .oe_i(p2_oe), .pu_i(p2_pu),
        .ext_on_i(ext_on), .ext_val_i(x2), .lvl_o(p2_i));
    gpd_pin_model #(.W(4)) m3_inst (.mclk_i(mclk_i), .drv_i(p3_o), .oe_i(p3_oe), .pu_i(p3_pu),
        .ext_on_i(ext_on), .ext_val_i(x3), .lvl_o(p3_i));
    // The open-drain port has no switchable pull-up, so that model input stays low.
    gpd_pin_model #(.W(4)) m5_inst (.mclk_i(mclk_i), .drv_i(p5_o), .oe_i(p5_oe), .pu_i(4'h0),
        .ext_on_i(ext_on), .ext_val_i(x5), .lvl_o(p5_i));

    task automatic test_done();
        $display("Checks made %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        addr_i = a;
        wdata_i = d;
        bit_i = 1'b0;
        wr_i = 1'b1;
        @(negedge mclk_i);
        wr_i = 1'b0;
        // Enables and pull-ups follow the direction register one edge late, so let it pass.
        @(negedge mclk_i);
    endtask

    task automatic wrb(input logic [15:0] a, input logic [2:0] sel, input logic v);
        @(negedge mclk_i);
        addr_i = a;
        wdata_i = {7'h00, v};
        bit_sel_i = sel;
        bit_i = 1'b1;
        wr_i = 1'b1;
        @(negedge mclk_i);
        wr_i = 1'b0;
        bit_i = 1'b0;
        @(negedge mclk_i);
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string name);
        int n;
        n = 0;
        @(negedge mclk_i);
        addr_i = a;
        rd_i = 1'b1;
        @(negedge mclk_i);
        rd_i = 1'b0;
        while (rvalid_o !== 1'b1 && n < 4) begin
            @(negedge mclk_i);
            n++;
        end
        if (n == 4) begin
            err_total++;
            $display("MISMATCH rvalid expected 1 seen %b", rvalid_o);
            test_done();
        end else begin
            chk(name, exp, rdata_o);
        end
    endtask

    // Interrupt set pulses are gathered over a few cycles, since their exact cycle is the design's choice.
    task automatic wr_irq(input logic [7:0] d, input logic [3:0] exp);
        logic [3:0] seen;
        seen = 4'h0;
        @(negedge mclk_i);
        addr_i = GPD_ADDR_PORT3;
        wdata_i = d;
        wr_i = 1'b1;
        repeat (3) begin
            @(negedge mclk_i);
            wr_i = 1'b0;
            seen = seen | irq_set;
        end
        chk("irq_set", 8'(exp), 8'(seen));
    endtask

    initial begin
        repeat (20) @(negedge mclk_i);
        rst_b_i = 1'b1;
        for (int i = 0; i < 5; i++) rd(dir_a[i], 8'hFF, "dir_reset");
        rd(GPD_ADDR_PU01, 8'h00, "pu01_reset");
        rd(GPD_ADDR_PU2, 8'h00, "pu2_reset");
        rd(GPD_ADDR_PU3, 8'h00, "pu3_reset");
        rd(16'hFF10, 8'h00, "unmapped");
        chk("p2_oe_reset", 8'h00, 8'(p2_oe));
        // Preload the latch while the pins are still inputs.
        wr(GPD_ADDR_PORT2, 8'h55);
        chk("p2_latch_in", 8'h55, 8'(p2_o));
        chk("p2_oe_in", 8'h00, 8'(p2_oe));
        rd(GPD_ADDR_PORT2, 8'h2A, "p2_read_in");
        chk("p2_latch_kept", 8'h55, 8'(p2_o));
        wr(GPD_ADDR_DIR2, 8'h00);
        chk("p2_oe_out", 8'h7F, 8'(p2_oe));
        chk("p2_drive", 8'h55, 8'(p2_i));
        rd(GPD_ADDR_DIR2, 8'h80, "dir2_fixed");
        rd(GPD_ADDR_PORT2, 8'h55, "p2_read_out");
        wrb(GPD_ADDR_PORT2, 3'h6, 1'b0);
        chk("p2_bit_clear", 8'h15, 8'(p2_o));
        rd(GPD_ADDR_PORT2, 8'h15, "p2_operand");
        wr(GPD_ADDR_PORT2, 8'h15 + 8'h01);
        chk("p2_sum", 8'h16, 8'(p2_i));
        // The upper unused pull-up bit 7 is written as zero.
        wr(GPD_ADDR_PU2, 8'h7F);
        chk("p2_pu_out", 8'h00, 8'(p2_pu));
        rd(GPD_ADDR_PU2, 8'h7F, "pu2_back");
        wrb(GPD_ADDR_DIR2, 3'h6, 1'b1);
        chk("p2_oe_bit", 8'h3F, 8'(p2_oe));
        chk("p2_pu_in", 8'h40, 8'(p2_pu));
        rd(GPD_ADDR_DIR2, 8'hC0, "dir2_bit");
        // Key-return pins 0 and 1 stay inputs, pins 2 and 3 become outputs.
        wr(GPD_ADDR_DIR0, 8'hF3);
        chk("p0_oe", 8'h0C, 8'(p0_oe));
        chk("p0_drive", GPD_LATCH_RST, 8'(p0_o));
        wr(GPD_ADDR_PU01, 8'h03);
        chk("p0_pu", 8'h03, 8'(p0_pu));
        chk("p1_pu", 8'h0F, 8'(p1_pu));
        wrb(GPD_ADDR_PU01, 3'h1, 1'b0);
        chk("p1_pu_off", 8'h00, 8'(p1_pu));
        wr(GPD_ADDR_DIR1, 8'hF3);
        chk("p1_oe", 8'h0C, 8'(p1_oe));
        wrb(GPD_ADDR_PORT1, 3'h2, 1'b1);
        chk("p1_rmw", 8'h05, 8'(p1_o));
        // Interrupt masking is assumed done by software before port 3 drives.
        wr(GPD_ADDR_DIR3, 8'hF0);
        chk("p3_oe", 8'h0F, 8'(p3_oe));
        wr_irq(8'h05, 4'h5);
        chk("p3_drive", 8'h05, 8'(p3_o));
        wr(GPD_ADDR_DIR3, 8'hFF);
        wr_irq(8'h0A, 4'h0);
        wr(GPD_ADDR_PU3, 8'h0F);
        chk("p3_pu", 8'h0F, 8'(p3_pu));
        rd(GPD_ADDR_PU3, 8'h0F, "pu3_back");
        wr(GPD_ADDR_DIR5, 8'hF0);
        wr(GPD_ADDR_PORT5, 8'h0A);
        chk("p5_oe", 8'h05, 8'(p5_oe));
        chk("p5_drive", 8'h00, 8'(p5_o));
        rd(GPD_ADDR_PORT5, 8'h0A, "p5_read");
        // Outside drivers let go, so only the enabled pull-ups hold port 0 high.
        wr(GPD_ADDR_DIR0, 8'hFF);
        chk("p0_pu_all", 8'h0F, 8'(p0_pu));
        ext_on = 1'b0;
        rd(GPD_ADDR_PORT0, 8'h0F, "p0_pulled");
        test_done();
    end
endmodule
`default_nettype wire
